//--- dv/cksp_top_bench.sv
// self-checking testbench for the clock select, divide and pll control slice
`timescale 1ns/1ps
`default_nettype none
module cksp_top_bench;
	logic        hclk     = 1'b0;
	logic        hresetn  = 1'b0;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0000_0000;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0000_0000;
	logic        sleep_en = 1'b0;
	logic [7:0]  cnt      = 8'h00;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic [9:0]  ck;
	logic        byp;
	logic        pdn;
	logic [1:0]  odv;
	logic [4:0]  idv;
	logic [8:0]  fdv;
	logic [9:0]  nf;
	logic [5:0]  nr;
	logic [2:0]  no;
	int          err_total = 0;
	int          checked   = 0;
	int          n[10];
	int          mux_e[4]  = '{64, 16, 4, 32};
	int          aud_e[4]  = '{64, 8, 4, 32};
	int          no_e[4]   = '{1, 2, 2, 4};
	logic [31:0] pc_v[6]   = '{32'h0000_C22E, 32'h0000_C22E, 32'h0001_C22E,
		32'h0002_C22E, 32'h000A_C22E, 32'h0006_C22E};
	logic        sl_v[6]   = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
	int          pe_v[6]   = '{8, 0, 0, 64, 32, 0};
	int          re_v[6]   = '{64, 64, 64, 64, 32, 64};
	logic        pd_v[6]   = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

	always #2 hclk = ~hclk;
	// source clocks: fast 8, osc 16, slow 32, pll 64, bus source 128 hclk periods
	always @(posedge hclk) cnt <= cnt + 8'h01;

	cksp_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_xtal_clk(cnt[2]),
		.slow_xtal_clk(cnt[4]), .int_osc_clk(cnt[3]), .pll_raw_clk(cnt[5]),
		.hclk_src_clk(cnt[6]), .uart_src_clk(cnt[2]), .adc_src_clk(cnt[2]),
		.system_sleep_enable(sleep_en), .pulse_pair_c_clk(ck[0]), .pulse_pair_b_clk(ck[1]),
		.freq_divider_clk(ck[2]), .audio_clk(ck[3]), .adc_clk(ck[4]), .uart_clk(ck[5]),
		.usb_clk(ck[6]), .sys_bus_clk(ck[7]), .pll_ref_clk(ck[9]), .pll_clk(ck[8]),
		.pll_bypass(byp), .pll_power_down(pdn), .pll_output_divider(odv),
		.pll_input_divider(idv), .pll_feedback_divider(fdv), .pll_nf(nf), .pll_nr(nr),
		.pll_no(no));

	// **********************************************************
	// shared tasks
	// **********************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr

	task rd(input logic [31:0] a, input logic [31:0] exp, input string what);
		logic [31:0] x;
		bus(1'b0, a, 32'h0000_0000, x);
		chk(x, exp, what);
		chk({31'h0, hresp}, 32'h0000_0000, "okay response");
	endtask : rd

	task count;
		logic [9:0] prev;
		for (int i = 0; i < 10; i++) n[i] = 0;
		repeat (64) @(posedge hclk);
		@(negedge hclk);
		prev = ck;
		repeat (512)
		begin
			@(negedge hclk);
			for (int i = 0; i < 10; i++) if (ck[i] === 1'b1 && prev[i] === 1'b0) n[i]++;
			prev = ck;
		end
		@(posedge hclk);
	endtask : count

	task near(input int i, input int exp, input string what);
		chk((n[i] + 1 >= exp && n[i] <= exp + 1) ? 32'h1 : 32'h0, 32'h1, what);
	endtask : near

	task complete_run;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// **********************************************************
	// tests
	// **********************************************************
	initial
	begin
		repeat (19) @(posedge hclk);
		chk({31'h0, pdn}, 32'h1, "power down in reset");
		chk({31'h0, hreadyout}, 32'h1, "ready in reset");
		@(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		rd({20'h0, cksp_pkg::ADDR_DIV_FACTORS}, cksp_pkg::RST_DIV_FACTORS, "div reset");
		rd({20'h0, cksp_pkg::ADDR_SRC_SEL2}, cksp_pkg::RST_SRC_SEL2, "sel reset");
		rd({20'h0, cksp_pkg::ADDR_PLL_CTRL}, cksp_pkg::RST_PLL_CTRL, "pll reset");
		chk({22'h0, nf}, 32'h0000_0030, "nf reset");
		chk({26'h0, nr}, 32'h0000_0003, "nr reset");
		chk({29'h0, no}, 32'h0000_0004, "no reset");
		wr(32'h0000_0018, 32'hFFFF_FFFF);
		rd(32'h0000_0018, 32'h00FF_0FFF, "div mask");
		wr(32'h0000_001C, 32'hFFFF_FFFF);
		rd(32'h0000_001C, 32'h0000_00FF, "sel mask");
		wr(32'h0000_0020, 32'hFFFF_FFFF);
		rd(32'h0000_0020, 32'h000F_FFFF, "pll mask");
		wr(32'h0000_0024, 32'hFFFF_FFFF);
		rd(32'h0000_0024, 32'h0000_0000, "unmapped");
		$display("test registers done");
		wr(32'h0000_0018, 32'h0000_0000);
		wr(32'h0000_0020, 32'h0000_C22E);
		for (int s = 0; s < 4; s++)
		begin
			// every source runs free, so old and new are both alive
			wr(32'h0000_001C, {24'h0, 2'(s), 2'(s), 2'(s), 2'(s)});
			count();
			near(0, mux_e[s], "pair c source");
			near(1, mux_e[s], "pair b source");
			near(2, mux_e[s], "freq divider source");
			near(3, aud_e[s], "audio source");
		end
		$display("test source select done");
		wr(32'h0000_0018, 32'h0003_0111);
		count();
		near(4, 16, "converter divide");
		near(5, 32, "uart divide");
		near(6, 4, "usb divide");
		near(7, 2, "bus divide");
		$display("test dividers done");
		for (int i = 0; i < 6; i++)
		begin
			sleep_en <= sl_v[i];
			wr(32'h0000_0020, pc_v[i]);
			count();
			near(8, pe_v[i], "pll output");
			near(9, re_v[i], "pll reference");
			chk({31'h0, pdn}, {31'h0, pd_v[i]}, "power down");
			chk({31'h0, byp}, {31'h0, pc_v[i][17]}, "bypass");
		end
		sleep_en <= 1'b0;
		for (int oc = 0; oc < 4; oc++)
		begin
			wr(32'h0000_0020, (32'(oc) << 14) | 32'h0000_0A64);
			repeat (4) @(posedge hclk);
			chk({29'h0, no}, 32'(no_e[oc]), "output factor");
			chk({30'h0, odv}, 32'(oc), "output divider");
			chk({27'h0, idv}, 32'h0000_0005, "input divider");
			chk({23'h0, fdv}, 32'h0000_0064, "feedback divider");
			chk({22'h0, nf}, 32'h0000_0066, "feedback factor");
			chk({26'h0, nr}, 32'h0000_0007, "input factor");
		end
		$display("test pll control done");
		complete_run();
	end

	initial
	begin
		#80000;
		err_total++;
		complete_run();
	end
endmodule : cksp_top_bench
`default_nettype wire

//--- verilog/cksp_pkg.sv
// constants for the clock select, divide and pll control slice
`default_nettype none
package cksp_pkg;
	// **********************************************************
	// register map, byte addresses within the 4 KB window
	// **********************************************************
	localparam int               ADDR_W          = 12;
	localparam logic [11:0]      ADDR_DIV_FACTORS = 12'h018;
	localparam logic [11:0]      ADDR_SRC_SEL2    = 12'h01C;
	localparam logic [11:0]      ADDR_PLL_CTRL    = 12'h020;
	localparam logic [31:0]      RST_DIV_FACTORS  = 32'h0000_0000;
	localparam logic [31:0]      RST_SRC_SEL2     = 32'h0000_00FF;
	localparam logic [31:0]      RST_PLL_CTRL     = 32'h0005_C22E;
	localparam logic [31:0]      MASK_DIV_FACTORS = 32'h00FF_0FFF;
	localparam logic [31:0]      MASK_SRC_SEL2    = 32'h0000_00FF;
	localparam logic [31:0]      MASK_PLL_CTRL    = 32'h000F_FFFF;
	// **********************************************************
	// field positions
	// **********************************************************
	localparam int               ADC_DIV_LSB      = 16;
	localparam int               ADC_DIV_W        = 8;
	localparam int               UART_DIV_LSB     = 8;
	localparam int               USB_DIV_LSB      = 4;
	localparam int               HCLK_DIV_LSB     = 0;
	localparam int               NARROW_DIV_W     = 4;
	localparam int               PAIR_C_SRC_LSB   = 6;
	localparam int               SEL_W            = 2;
	localparam int               PLL_REF_BIT      = 19;
	localparam int               PLL_GATE_BIT     = 18;
	localparam int               PLL_BYP_BIT      = 17;
	localparam int               PLL_PD_BIT       = 16;
	localparam int               PLL_OUTDIV_LSB   = 14;
	localparam int               PLL_OUTDIV_W     = 2;
	localparam int               PLL_INDIV_LSB    = 9;
	localparam int               PLL_INDIV_W      = 5;
	localparam int               PLL_FBDIV_LSB    = 0;
	localparam int               PLL_FBDIV_W      = 9;
	localparam int               PLL_FACTOR_ADD   = 2;
	// **********************************************************
	// source codes and synchronised pin indices
	// **********************************************************
	localparam logic [1:0]       SRC_FAST_XTAL    = 2'h0;
	localparam logic [1:0]       SRC_ALT          = 2'h1;
	localparam logic [1:0]       SRC_SYS_BUS      = 2'h2;
	localparam logic [1:0]       SRC_INT_OSC      = 2'h3;
	localparam int               PIN_FAST         = 0;
	localparam int               PIN_SLOW         = 1;
	localparam int               PIN_OSC          = 2;
	localparam int               PIN_PLL          = 3;
	localparam int               PIN_HCLK_SRC     = 4;
	localparam int               PIN_UART_SRC     = 5;
	localparam int               PIN_ADC_SRC      = 6;
	localparam int               PIN_N            = 7;
endpackage : cksp_pkg
`default_nettype wire

//--- verilog/cksp_top.sv
// clock source selection, clock dividers and pll control with ahb-lite registers
//
// Function
// - pair c clock from bits 7:6: fast, slow, bus clock, oscillator
// - channels six and seven share one selected clock and prescaler
// - pair b clock from bits 5:4, same encoding, one shared prescaler
// - frequency divider input from bits 3:2: fast, slow, bus, oscillator
// - audio clock from bits 1:0: fast, pll output, bus, oscillator
// - converter clock is its source divided by bits 23:16 plus one
// - uart clock is its source divided by bits 11:8 plus one
// - usb clock is pll output divided by bits 7:4 plus one
// - bus clock is its source divided by bits 3:0 plus one
// - pll reference is oscillator when bit 19 set, else fast crystal
// - bit 18 set holds pll output low, clear lets it through
// - bit 17 set with bit 18 clear passes pll reference straight to pll output
// - bit 16 set powers the pll down; reset state is powered down
// - system sleep enable also powers the pll down
// - output divider bits 15:14, input 13:9, feedback 8:0
// - fout equals fin times feedback plus two over input plus two, over no
// - output divider code 00 gives 1, 01 and 10 give 2, 11 gives 4
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cksp_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        fast_xtal_clk,
	input  wire logic        slow_xtal_clk,
	input  wire logic        int_osc_clk,
	input  wire logic        pll_raw_clk,
	input  wire logic        hclk_src_clk,
	input  wire logic        uart_src_clk,
	input  wire logic        adc_src_clk,
	input  wire logic        system_sleep_enable,
	output logic             pulse_pair_c_clk,
	output logic             pulse_pair_b_clk,
	output logic             freq_divider_clk,
	output logic             audio_clk,
	output logic             adc_clk,
	output logic             uart_clk,
	output logic             usb_clk,
	output logic             sys_bus_clk,
	output logic             pll_ref_clk,
	output logic             pll_clk,
	output logic             pll_bypass,
	output logic             pll_power_down,
	output logic [1:0]       pll_output_divider,
	output logic [4:0]       pll_input_divider,
	output logic [8:0]       pll_feedback_divider,
	output logic [9:0]       pll_nf,
	output logic [5:0]       pll_nr,
	output logic [2:0]       pll_no
);
	// **********************************************************
	// declarations
	// **********************************************************
	logic [31:0]                  clock_divide_factors_r;
	logic [31:0]                  clock_source_select_second_r;
	logic [31:0]                  pll_control_r;
	logic [31:0]                  clock_divide_factors_nxt;
	logic [31:0]                  clock_source_select_second_nxt;
	logic [31:0]                  pll_control_nxt;
	logic                         dph_wr_r;
	logic [cksp_pkg::ADDR_W-1:0]  dph_addr_r;
	logic                         hreadyout_r;
	logic [31:0]                  hrdata_r;
	logic                         aph_take;
	logic [cksp_pkg::PIN_N-1:0]   pin_in;
	logic [cksp_pkg::PIN_N-1:0]   sync1_r;
	logic [cksp_pkg::PIN_N-1:0]   sync2_r;
	logic [3:0]                   mux_out_r;
	logic [1:0]                   mux_cur_r [4];
	logic [3:0]                   mux_src [4];
	logic [1:0]                   mux_want [4];
	logic [3:0]                   div_out_r;
	logic [3:0]                   div_src;
	logic [3:0]                   div_src_d_r;
	logic [7:0]                   div_cnt_r [4];
	logic [7:0]                   div_cur_r [4];
	logic [7:0]                   div_req [4];
	logic                         pll_ref;
	logic                         pll_ref_r;
	logic                         pll_out_r;
	logic                         pll_pd_r;
	logic                         pll_byp_r;
	logic [1:0]                   pll_odiv_r;
	logic [4:0]                   pll_idiv_r;
	logic [8:0]                   pll_fdiv_r;
	logic [9:0]                   pll_nf_r;
	logic [5:0]                   pll_nr_r;
	logic [2:0]                   pll_no_r;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// **********************************************************
	// functions
	// **********************************************************
	function automatic logic [31:0] read_word(
		input logic [cksp_pkg::ADDR_W-1:0] a,
		input logic [31:0]                 dv,
		input logic [31:0]                 sl,
		input logic [31:0]                 pc
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			cksp_pkg::ADDR_DIV_FACTORS: v = dv;
			cksp_pkg::ADDR_SRC_SEL2:    v = sl;
			cksp_pkg::ADDR_PLL_CTRL:    v = pc;
			default:                    v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_word

	function automatic logic [2:0] out_factor(input logic [1:0] code);
		logic [2:0] f;
		case (code)
			2'h0:    f = 3'h1;
			2'h1:    f = 3'h2;
			2'h2:    f = 3'h2;
			default: f = 3'h4;
		endcase
		return f;
	endfunction : out_factor

	function automatic logic [31:0] merge_write(
		input logic                        wr,
		input logic [cksp_pkg::ADDR_W-1:0] a,
		input logic [cksp_pkg::ADDR_W-1:0] own,
		input logic [31:0]                 old,
		input logic [31:0]                 data,
		input logic [31:0]                 mask
	);
		logic [31:0] v;
		v = old;
		if (wr && (a == own))
		begin
			v = data & mask;
		end
		return v;
	endfunction : merge_write

	// **********************************************************
	// ahb-lite slave, zero wait states, always okay
	// **********************************************************
	assign aph_take = hsel && hready && htrans[1];

	always_comb
	begin
		clock_divide_factors_nxt = merge_write(dph_wr_r, dph_addr_r,
			cksp_pkg::ADDR_DIV_FACTORS, clock_divide_factors_r, hwdata,
			cksp_pkg::MASK_DIV_FACTORS);
		clock_source_select_second_nxt = merge_write(dph_wr_r, dph_addr_r,
			cksp_pkg::ADDR_SRC_SEL2, clock_source_select_second_r, hwdata,
			cksp_pkg::MASK_SRC_SEL2);
		pll_control_nxt = merge_write(dph_wr_r, dph_addr_r,
			cksp_pkg::ADDR_PLL_CTRL, pll_control_r, hwdata,
			cksp_pkg::MASK_PLL_CTRL);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_wr_r    <= 1'b0;
			dph_addr_r  <= '0;
			hreadyout_r <= 1'b1;
			hrdata_r    <= 32'h0000_0000;
		end
		else
		begin
			hreadyout_r <= 1'b1;
			if (hready)
			begin
				dph_wr_r   <= aph_take && hwrite;
				dph_addr_r <= haddr[cksp_pkg::ADDR_W-1:0];
			end
			// read data sees a write still in its data phase
			if (aph_take && !hwrite)
			begin
				hrdata_r <= read_word(haddr[cksp_pkg::ADDR_W-1:0],
					clock_divide_factors_nxt, clock_source_select_second_nxt,
					pll_control_nxt);
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clock_divide_factors_r       <= cksp_pkg::RST_DIV_FACTORS;
			clock_source_select_second_r <= cksp_pkg::RST_SRC_SEL2;
			pll_control_r                <= cksp_pkg::RST_PLL_CTRL;
		end
		else
		begin
			clock_divide_factors_r       <= clock_divide_factors_nxt;
			clock_source_select_second_r <= clock_source_select_second_nxt;
			pll_control_r                <= pll_control_nxt;
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	// **********************************************************
	// pin synchronisers
	// **********************************************************
	assign pin_in = {adc_src_clk, uart_src_clk, hclk_src_clk, pll_raw_clk,
		int_osc_clk, slow_xtal_clk, fast_xtal_clk};

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
		end
	end

	// **********************************************************
	// glitch-free source multiplexers
	// **********************************************************
	// index 0 pair c, 1 pair b, 2 frequency divider, 3 audio
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			mux_src[i][cksp_pkg::SRC_FAST_XTAL] = sync2_r[cksp_pkg::PIN_FAST];
			mux_src[i][cksp_pkg::SRC_ALT]       = sync2_r[cksp_pkg::PIN_SLOW];
			mux_src[i][cksp_pkg::SRC_SYS_BUS]   = div_out_r[3];
			mux_src[i][cksp_pkg::SRC_INT_OSC]   = sync2_r[cksp_pkg::PIN_OSC];
			mux_want[i] = clock_source_select_second_r[
				cksp_pkg::PAIR_C_SRC_LSB - 2*i +: cksp_pkg::SEL_W];
		end
		mux_src[3][cksp_pkg::SRC_ALT] = pll_out_r;
	end

	for (genvar g = 0; g < 4; g++)
	begin : g_mux
		// hand over only while both old output and new source are low
		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				mux_cur_r[g] <= cksp_pkg::RST_SRC_SEL2[1:0];
				mux_out_r[g] <= 1'b0;
			end
			else if ((mux_want[g] != mux_cur_r[g]) && !mux_out_r[g]
				&& !mux_src[g][mux_want[g]])
			begin
				mux_cur_r[g] <= mux_want[g];
				mux_out_r[g] <= 1'b0;
			end
			else
			begin
				mux_out_r[g] <= mux_src[g][mux_cur_r[g]];
			end
		end
		a_mux_switch_low : assert property ($changed(mux_cur_r[g])
			|-> !$past(mux_out_r[g]) && !mux_out_r[g])
			else $error("source switched while output high");
	end

	// one output per pair: both channels share clock and prescaler
	assign pulse_pair_c_clk = mux_out_r[0];
	assign pulse_pair_b_clk = mux_out_r[1];
	assign freq_divider_clk = mux_out_r[2];
	assign audio_clk        = mux_out_r[3];

	// **********************************************************
	// clock dividers: 0 converter, 1 uart, 2 usb, 3 system bus
	// **********************************************************
	always_comb
	begin
		div_src[0] = sync2_r[cksp_pkg::PIN_ADC_SRC];
		div_src[1] = sync2_r[cksp_pkg::PIN_UART_SRC];
		div_src[2] = pll_out_r;
		div_src[3] = sync2_r[cksp_pkg::PIN_HCLK_SRC];
		div_req[0] = clock_divide_factors_r[
			cksp_pkg::ADC_DIV_LSB +: cksp_pkg::ADC_DIV_W];
		div_req[1] = {4'h0, clock_divide_factors_r[
			cksp_pkg::UART_DIV_LSB +: cksp_pkg::NARROW_DIV_W]};
		div_req[2] = {4'h0, clock_divide_factors_r[
			cksp_pkg::USB_DIV_LSB +: cksp_pkg::NARROW_DIV_W]};
		div_req[3] = {4'h0, clock_divide_factors_r[
			cksp_pkg::HCLK_DIV_LSB +: cksp_pkg::NARROW_DIV_W]};
	end

	for (genvar g = 0; g < 4; g++)
	begin : g_div
		logic       rise;
		logic       wrap;
		logic [7:0] n_eff;
		logic [7:0] cnt_nxt;
		logic [8:0] half;
		assign rise    = div_src[g] && !div_src_d_r[g];
		assign wrap    = rise && (div_cnt_r[g] == div_cur_r[g]);
		assign n_eff   = wrap ? div_req[g] : div_cur_r[g];
		assign cnt_nxt = wrap ? 8'h00 : div_cnt_r[g] + 8'h01;
		assign half    = ({1'b0, n_eff} + 9'h002) >> 1;

		// divide by n+1 source periods, high for the first half after the wrap
		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				div_src_d_r[g] <= 1'b0;
				div_cnt_r[g]   <= 8'h00;
				div_cur_r[g]   <= 8'h00;
				div_out_r[g]   <= 1'b0;
			end
			else
			begin
				div_src_d_r[g] <= div_src[g];
				if (rise)
				begin
					div_cnt_r[g] <= cnt_nxt;
					div_cur_r[g] <= n_eff;
					div_out_r[g] <= ({1'b0, cnt_nxt} < half);
				end
				else if (div_cur_r[g] == 8'h00)
				begin
					div_out_r[g] <= div_src[g];
				end
			end
		end
		sequence s_period_end;
			rise && (div_cnt_r[g] == div_cur_r[g]);
		endsequence
		a_div_load_edge : assert property ($changed(div_cur_r[g])
			|-> $past(rise && (div_cnt_r[g] == div_cur_r[g])))
			else $error("divide value taken mid period");
		a_div_wrap_zero : assert property (s_period_end
			|=> div_cnt_r[g] == 8'h00 && div_out_r[g])
			else $error("divider did not restart high");
	end

	assign adc_clk     = div_out_r[0];
	assign uart_clk    = div_out_r[1];
	assign usb_clk     = div_out_r[2];
	assign sys_bus_clk = div_out_r[3];

	// **********************************************************
	// pll control
	// **********************************************************
	assign pll_ref = pll_control_r[cksp_pkg::PLL_REF_BIT]
		? sync2_r[cksp_pkg::PIN_OSC] : sync2_r[cksp_pkg::PIN_FAST];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pll_ref_r <= 1'b0;
			pll_out_r <= 1'b0;
		end
		else
		begin
			pll_ref_r <= pll_ref;
			if (pll_control_r[cksp_pkg::PLL_GATE_BIT])
			begin
				pll_out_r <= 1'b0;
			end
			else if (pll_control_r[cksp_pkg::PLL_BYP_BIT])
			begin
				pll_out_r <= pll_ref;
			end
			else
			begin
				// a powered-down loop gives no clock
				pll_out_r <= sync2_r[cksp_pkg::PIN_PLL] && !pll_pd_r;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pll_pd_r   <= 1'b1;
			pll_byp_r  <= 1'b0;
			pll_odiv_r <= '0;
			pll_idiv_r <= '0;
			pll_fdiv_r <= '0;
			pll_nf_r   <= '0;
			pll_nr_r   <= '0;
			pll_no_r   <= '0;
		end
		else
		begin
			pll_pd_r   <= pll_control_r[cksp_pkg::PLL_PD_BIT]
				|| system_sleep_enable;
			pll_byp_r  <= pll_control_r[cksp_pkg::PLL_BYP_BIT];
			pll_odiv_r <= pll_control_r[
				cksp_pkg::PLL_OUTDIV_LSB +: cksp_pkg::PLL_OUTDIV_W];
			pll_idiv_r <= pll_control_r[
				cksp_pkg::PLL_INDIV_LSB +: cksp_pkg::PLL_INDIV_W];
			pll_fdiv_r <= pll_control_r[
				cksp_pkg::PLL_FBDIV_LSB +: cksp_pkg::PLL_FBDIV_W];
			pll_nf_r   <= {1'b0, pll_control_r[
				cksp_pkg::PLL_FBDIV_LSB +: cksp_pkg::PLL_FBDIV_W]}
				+ 10'(cksp_pkg::PLL_FACTOR_ADD);
			pll_nr_r   <= {1'b0, pll_control_r[
				cksp_pkg::PLL_INDIV_LSB +: cksp_pkg::PLL_INDIV_W]}
				+ 6'(cksp_pkg::PLL_FACTOR_ADD);
			pll_no_r   <= out_factor(pll_control_r[
				cksp_pkg::PLL_OUTDIV_LSB +: cksp_pkg::PLL_OUTDIV_W]);
		end
	end

	assign pll_ref_clk          = pll_ref_r;
	assign pll_clk              = pll_out_r;
	assign pll_bypass           = pll_byp_r;
	assign pll_power_down       = pll_pd_r;
	assign pll_output_divider   = pll_odiv_r;
	assign pll_input_divider    = pll_idiv_r;
	assign pll_feedback_divider = pll_fdiv_r;
	assign pll_nf               = pll_nf_r;
	assign pll_nr               = pll_nr_r;
	assign pll_no               = pll_no_r;

	// **********************************************************
	// checks
	// **********************************************************
	a_pll_pd_bit : assert property (pll_control_r[cksp_pkg::PLL_PD_BIT]
		|=> pll_power_down)
		else $error("pll not powered down by its bit");
	a_pll_pd_sleep : assert property (system_sleep_enable
		|=> pll_power_down)
		else $error("pll not powered down in sleep");
	a_pll_gate_low : assert property (
		$past(pll_control_r[cksp_pkg::PLL_GATE_BIT]) |-> !pll_clk)
		else $error("gated pll output not low");
	a_pll_bypass_ref : assert property (
		!pll_control_r[cksp_pkg::PLL_GATE_BIT] && pll_control_r[cksp_pkg::PLL_BYP_BIT]
		|=> pll_clk == pll_ref_clk)
		else $error("bypass does not pass the reference");
	a_pll_ref_pick : assert property (
		pll_control_r[cksp_pkg::PLL_REF_BIT] && $stable(pll_control_r)
		|=> pll_ref_clk == $past(sync2_r[cksp_pkg::PIN_OSC]))
		else $error("pll reference not the oscillator");
	// reset-release edge excluded: outputs only follow one edge later
	a_pll_nf_value : assert property (hresetn |=> pll_nf == {1'b0,
		$past(pll_control_r[cksp_pkg::PLL_FBDIV_LSB +: cksp_pkg::PLL_FBDIV_W])}
		+ 10'(cksp_pkg::PLL_FACTOR_ADD))
		else $error("feedback factor wrong");
	a_pll_no_map : assert property (hresetn
		&& pll_control_r[cksp_pkg::PLL_OUTDIV_LSB +: cksp_pkg::PLL_OUTDIV_W] == 2'h3
		|=> pll_no == 3'h4 && pll_output_divider == 2'h3)
		else $error("output factor wrong for code three");
	a_bus_okay : assert property (aph_take && !hwrite
		|=> hreadyout && !hresp && hrdata == read_word(dph_addr_r,
		clock_divide_factors_r, clock_source_select_second_r, pll_control_r))
		else $error("bus read answer wrong or not okay");
endmodule : cksp_top
`default_nettype wire
